// [pnd_pkg.sv]
// Constants, register map and field layout of the next-data staging block
// Behaviour
// - Two 8-bit read/write next-pattern registers
// - Selected trigger copies group next bits out
// - Same triggers: high byte at one address
// - Different triggers: nibbles at separate addresses
// - Split view: unused nibble reads one, ignored
// - 8-bit read/write trigger-select register
// - Group 3 field picks timer channel 0-3
// - Group 2 field picks timer channel 0-3
// - Only enabled bits copy on trigger
// - Non-overlap: match A copies enabled bits
// - Non-overlap: match B copies only zeros
package pnd_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 8;
  localparam int NIB_W = 4;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 4;
  localparam int CHAN_N = 4;
  localparam int BUF_W = IDX_W + DATA_W;
  localparam int BUF_DEPTH = 2;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFS_SEL = 12'h000;
  localparam logic [11:0] OFS_HI_JOINT = 12'h004;
  localparam logic [11:0] OFS_HI_UPPER = 12'h008;
  localparam logic [11:0] OFS_HI_LOWER = 12'h00C;
  localparam logic [11:0] OFS_LO_JOINT = 12'h010;
  localparam logic [11:0] OFS_BIT_EN = 12'h014;
  localparam logic [11:0] OFS_MODE = 12'h018;
  localparam logic [11:0] OFS_PIN = 12'h01C;

  // ****************************************
  // Internal register index codes carried through the write buffer
  // ****************************************
  localparam logic [3:0] IDX_SEL = 4'h0;
  localparam logic [3:0] IDX_HI_JOINT = 4'h1;
  localparam logic [3:0] IDX_HI_UPPER = 4'h2;
  localparam logic [3:0] IDX_HI_LOWER = 4'h3;
  localparam logic [3:0] IDX_LO_JOINT = 4'h4;
  localparam logic [3:0] IDX_BIT_EN = 4'h5;
  localparam logic [3:0] IDX_MODE = 4'h6;
  localparam logic [3:0] IDX_PIN = 4'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int G3_SEL_POS = 6;
  localparam int G2_SEL_POS = 4;
  localparam int G3_NOV_POS = 3;
  localparam int G2_NOV_POS = 2;
  localparam int NIB_HI_POS = 4;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [7:0] SEL_RST = 8'hFF;
  localparam logic [7:0] MODE_RST = 8'hF0;
  localparam logic [7:0] NEXT_RST = 8'h00;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] PIN_RST = 8'h00;
  localparam logic [3:0] NIB_ONES = 4'hF;
endpackage : pnd_pkg

// [pnd_buf2.sv]
// Small flop-based FIFO that holds queued register writes
`timescale 1ns/100ps
module pnd_buf2 #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  import pnd_pkg::*;

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // Count is one bit wider than the pointers so that full and empty differ
  localparam logic [PTR_W:0] CNT_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [PTR_W:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != CNT_FULL);
  assign out_valid_out = (count_reg != '0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end
endmodule : pnd_buf2

// [pnd_grp_xfer.sv]
// Trigger decode and transfer mask for one four-bit output group
`timescale 1ns/100ps
module pnd_grp_xfer (
  input wire logic [1:0] sel_in,
  input wire logic nov_in,
  input wire logic [pnd_pkg::CHAN_N-1:0] cm_a_in,
  input wire logic [pnd_pkg::CHAN_N-1:0] cm_b_in,
  input wire logic [pnd_pkg::NIB_W-1:0] next_in,
  input wire logic [pnd_pkg::NIB_W-1:0] en_in,
  output logic event_out,
  output logic [pnd_pkg::NIB_W-1:0] mask_out
);
  import pnd_pkg::*;

  logic hit_a;
  logic hit_b;

  assign hit_a = cm_a_in[sel_in];
  assign hit_b = cm_b_in[sel_in] && nov_in;
  assign event_out = hit_a || hit_b;

  always_comb begin
    if (hit_a) begin
      mask_out = en_in;
    end else if (hit_b) begin
      mask_out = en_in & ~next_in;
    end else begin
      mask_out = '0;
    end
  end
endmodule : pnd_grp_xfer

// [pnd_next_data.sv]
// Next-pattern staging, trigger selection and APB register slave
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module pnd_next_data (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [pnd_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [pnd_pkg::CHAN_N-1:0] cm_a_in,
  input wire logic [pnd_pkg::CHAN_N-1:0] cm_b_in,
  output logic [pnd_pkg::DATA_W-1:0] pin_pattern_high_out
);
  import pnd_pkg::*;

  typedef enum logic [1:0] {AP_IDLE, AP_ACCESS, AP_RESP} pnd_apb_state_t;

  // ****************************************
  // Address decode
  // ****************************************
  // Returns {legal, view_dependent, index}; the high views follow the trigger pairing
  function automatic logic [IDX_W+1:0] pnd_decode(input logic [ADDR_W-1:0] addr,
                                                  input logic same);
    logic [IDX_W+1:0] res;
    res = {2'b00, IDX_SEL};
    unique case (addr)
      OFS_SEL: res = {2'b10, IDX_SEL};
      OFS_HI_JOINT: res = {same, 1'b1, IDX_HI_JOINT};
      OFS_HI_UPPER: res = {!same, 1'b1, IDX_HI_UPPER};
      OFS_HI_LOWER: res = {!same, 1'b1, IDX_HI_LOWER};
      OFS_LO_JOINT: res = {2'b10, IDX_LO_JOINT};
      OFS_BIT_EN: res = {2'b10, IDX_BIT_EN};
      OFS_MODE: res = {2'b10, IDX_MODE};
      OFS_PIN: res = {2'b10, IDX_PIN};
      default: res = {2'b00, IDX_SEL};
    endcase
    return res;
  endfunction : pnd_decode

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] sel_reg;
  logic [7:0] mode_reg;
  logic [7:0] next_hi_reg;
  logic [7:0] next_lo_reg;
  logic [7:0] en_reg;
  logic [7:0] pin_reg;
  pnd_apb_state_t ap_state_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic push_reg;

  logic same_trig;
  logic [IDX_W+1:0] dec;
  logic dec_ok;
  logic dec_view;
  logic can_done;
  logic [7:0] rd_val;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_empty;
  logic [BUF_W-1:0] buf_out_data;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_dat;
  logic drain_ok;
  logic drain;
  logic ev3;
  logic ev2;
  logic [3:0] mask3;
  logic [3:0] mask2;
  logic [7:0] xfer_mask;

  assign same_trig = (sel_reg[G3_SEL_POS +: 2] == sel_reg[G2_SEL_POS +: 2]);
  assign dec = pnd_decode(paddr_in, same_trig);
  assign dec_ok = dec[IDX_W+1];
  assign dec_view = dec[IDX_W];

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign pin_pattern_high_out = pin_reg;

  // ****************************************
  // Group trigger decode
  // ****************************************
  pnd_grp_xfer u_grp3 (
    .sel_in(sel_reg[G3_SEL_POS +: 2]),
    .nov_in(mode_reg[G3_NOV_POS]),
    .cm_a_in(cm_a_in),
    .cm_b_in(cm_b_in),
    .next_in(next_hi_reg[NIB_HI_POS +: NIB_W]),
    .en_in(en_reg[NIB_HI_POS +: NIB_W]),
    .event_out(ev3),
    .mask_out(mask3)
  );

  pnd_grp_xfer u_grp2 (
    .sel_in(sel_reg[G2_SEL_POS +: 2]),
    .nov_in(mode_reg[G2_NOV_POS]),
    .cm_a_in(cm_a_in),
    .cm_b_in(cm_b_in),
    .next_in(next_hi_reg[NIB_W-1:0]),
    .en_in(en_reg[NIB_W-1:0]),
    .event_out(ev2),
    .mask_out(mask2)
  );

  assign xfer_mask = {mask3, mask2};

  // ****************************************
  // Write buffer
  // ****************************************
  // Queued writes drain only in cycles without a group event, so a transfer
  // never sees a half-updated pattern; the cost is a stall of one cycle per event
  assign drain_ok = !(ev3 || ev2);
  assign drain = buf_out_valid && drain_ok;
  assign buf_empty = !buf_out_valid;
  assign wr_idx = buf_out_data[BUF_W-1 -: IDX_W];
  assign wr_dat = buf_out_data[DATA_W-1:0];

  pnd_buf2 #(
    .WIDTH(BUF_W),
    .DEPTH(BUF_DEPTH)
  ) u_wbuf (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(push_reg),
    .in_ready_out(buf_in_ready),
    .in_data_in({dec[IDX_W-1:0], pwdata_in[DATA_W-1:0]}),
    .out_valid_out(buf_out_valid),
    .out_ready_in(drain_ok),
    .out_data_out(buf_out_data)
  );

  // ****************************************
  // APB slave
  // ****************************************
  // Legal reads and mapping-dependent writes wait for the queue to empty, so they
  // see the trigger pairing that all earlier writes left behind
  always_comb begin
    if (!dec_ok) begin
      can_done = 1'b1;
    end else if (!pwrite_in || dec_view) begin
      can_done = buf_empty;
    end else begin
      can_done = buf_in_ready;
    end
  end

  always_comb begin
    unique case (dec[IDX_W-1:0])
      IDX_SEL: rd_val = sel_reg;
      IDX_HI_JOINT: rd_val = next_hi_reg;
      IDX_HI_UPPER: rd_val = {next_hi_reg[NIB_HI_POS +: NIB_W], NIB_ONES};
      IDX_HI_LOWER: rd_val = {NIB_ONES, next_hi_reg[NIB_W-1:0]};
      IDX_LO_JOINT: rd_val = next_lo_reg;
      IDX_BIT_EN: rd_val = en_reg;
      IDX_MODE: rd_val = mode_reg;
      IDX_PIN: rd_val = pin_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ap_state_reg <= AP_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      push_reg <= 1'b0;
    end else begin
      unique case (ap_state_reg)
        AP_IDLE: begin
          if (psel_in) begin
            ap_state_reg <= AP_ACCESS;
          end
        end
        AP_ACCESS: begin
          if (psel_in && penable_in && can_done) begin
            ap_state_reg <= AP_RESP;
            pready_reg <= 1'b1;
            pslverr_reg <= !dec_ok;
            prdata_reg <= (pwrite_in || !dec_ok) ? 32'h00000000 : {24'h000000, rd_val};
            push_reg <= pwrite_in && dec_ok && pstrb_in[0];
          end
        end
        AP_RESP: begin
          ap_state_reg <= AP_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          push_reg <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Register updates from the queue
  // ****************************************
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sel_reg <= SEL_RST;
    end else if (drain && wr_idx == IDX_SEL) begin
      sel_reg <= wr_dat;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      next_hi_reg <= NEXT_RST;
    end else if (drain) begin
      unique case (wr_idx)
        IDX_HI_JOINT: next_hi_reg <= wr_dat;
        IDX_HI_UPPER: next_hi_reg[NIB_HI_POS +: NIB_W] <= wr_dat[NIB_HI_POS +: NIB_W];
        IDX_HI_LOWER: next_hi_reg[NIB_W-1:0] <= wr_dat[NIB_W-1:0];
        default: next_hi_reg <= next_hi_reg;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      next_lo_reg <= NEXT_RST;
    end else if (drain && wr_idx == IDX_LO_JOINT) begin
      next_lo_reg <= wr_dat;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      en_reg <= EN_RST;
      mode_reg <= MODE_RST;
    end else if (drain) begin
      if (wr_idx == IDX_BIT_EN) begin
        en_reg <= wr_dat;
      end
      if (wr_idx == IDX_MODE) begin
        mode_reg <= wr_dat;
      end
    end
  end

  // Software may only set the initial level of bits that are not under pulse control
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_reg <= PIN_RST;
    end else if (ev3 || ev2) begin
      pin_reg <= (pin_reg & ~xfer_mask) | (next_hi_reg & xfer_mask);
    end else if (drain && wr_idx == IDX_PIN) begin
      pin_reg <= (pin_reg & en_reg) | (wr_dat & ~en_reg);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic hi_a;
  logic hi_b;
  logic lo_a;
  logic done;
  logic cpu_pin;
  assign hi_a = cm_a_in[sel_reg[G3_SEL_POS +: 2]];
  assign hi_b = cm_b_in[sel_reg[G3_SEL_POS +: 2]];
  assign lo_a = cm_a_in[sel_reg[G2_SEL_POS +: 2]];
  assign done = psel_in && penable_in && pready_reg;
  assign cpu_pin = drain && wr_idx == IDX_PIN;

  property p_hi_copy;
    hi_a |=> pin_reg[7:4] == (($past(next_hi_reg[7:4]) & $past(en_reg[7:4]))
                             | ($past(pin_reg[7:4]) & ~$past(en_reg[7:4])));
  endproperty
  a_hi_copy: assert property (p_hi_copy) else $error("group 3 copy wrong");

  property p_lo_hold;
    (!ev2 && !cpu_pin) |=> pin_reg[3:0] == $past(pin_reg[3:0]);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("group 2 changed without trigger");

  property p_nov_b;
    (hi_b && !hi_a && mode_reg[G3_NOV_POS]) |=>
      ((pin_reg[7:4] ^ $past(pin_reg[7:4])) & $past(next_hi_reg[7:4])) == 4'h0;
  endproperty
  a_nov_b: assert property (p_nov_b) else $error("match B copied a one");

  property p_norm_b;
    (hi_b && !hi_a && !mode_reg[G3_NOV_POS] && !cpu_pin) |=> $stable(pin_reg[7:4]);
  endproperty
  a_norm_b: assert property (p_norm_b) else $error("match B acted in normal mode");

  property p_lo_sel;
    (lo_a && $past(sel_reg) == sel_reg && en_reg[3:0] == 4'hF) |=>
      pin_reg[3:0] == $past(next_hi_reg[3:0]);
  endproperty
  a_lo_sel: assert property (p_lo_sel) else $error("group 2 select ignored");

  property p_split_read;
    (done && !pwrite_in && paddr_in == OFS_HI_UPPER && !pslverr_reg) |->
      prdata_reg[3:0] == 4'hF && prdata_reg[31:8] == 24'h000000;
  endproperty
  a_split_read: assert property (p_split_read) else $error("split view pad not ones");

  property p_lower_read;
    (done && !pwrite_in && paddr_in == OFS_HI_LOWER && !pslverr_reg) |->
      prdata_reg[7:4] == 4'hF && prdata_reg[31:8] == 24'h000000;
  endproperty
  a_lower_read: assert property (p_lower_read) else $error("lower view pad not ones");

  // A refused transfer must neither return data nor queue a write
  property p_err_quiet;
    (pready_reg && pslverr_reg) |-> prdata_reg == 32'h00000000 && !push_reg;
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("refused transfer had effect");

  property p_joint_err;
    (done && paddr_in == OFS_HI_JOINT) |-> pslverr_reg == !same_trig;
  endproperty
  a_joint_err: assert property (p_joint_err) else $error("joint map error wrong");

  property p_view_err;
    (done && paddr_in == OFS_HI_LOWER) |-> pslverr_reg == same_trig;
  endproperty
  a_view_err: assert property (p_view_err) else $error("split map error wrong");

  property p_sel_store;
    (drain && wr_idx == IDX_SEL) |=> sel_reg == $past(wr_dat);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("select write lost");

  property p_ready_pulse;
    pready_reg |=> !pready_reg;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held over one cycle");

  c_hi_update: cover property (hi_a && en_reg[7:4] != 4'h0);
  c_nov_b: cover property (hi_b && !hi_a && mode_reg[G3_NOV_POS]);
  c_full_stall: cover property (psel_in && penable_in && pwrite_in && !buf_in_ready);
  c_split: cover property (done && !same_trig && paddr_in == OFS_HI_UPPER);
endmodule : pnd_next_data

// [pnd_timer_model.sv]
// Timer unit model that issues compare-match strobes to the staging block
`timescale 1ns/100ps
module pnd_timer_model (
  input wire logic clk_in,
  input wire logic nrst_in,
  output logic [pnd_pkg::CHAN_N-1:0] cm_a_out,
  output logic [pnd_pkg::CHAN_N-1:0] cm_b_out
);
  import pnd_pkg::*;
  initial begin
    cm_a_out = '0;
    cm_b_out = '0;
  end
  // ****************************************
  // Strobe generation
  // ****************************************
  // A slow timer is modelled by a long idle gap before the strobe
  task automatic match(input int ch, input logic is_b, input int gap);
    logic [CHAN_N-1:0] hit;
    hit = 4'h1 << ch;
    // No strobe is issued while the block is held in reset
    wait (nrst_in === 1'b1);
    repeat (gap) @(posedge clk_in);
    if (is_b) begin
      cm_b_out <= hit;
    end else begin
      cm_a_out <= hit;
    end
    @(posedge clk_in);
    cm_a_out <= '0;
    cm_b_out <= '0;
  endtask : match
endmodule : pnd_timer_model

// [test_pulse_next_data_trigger_select.sv]
// Self-checking testbench of the next-pattern staging block
`timescale 1ns/100ps
module test_pulse_next_data_trigger_select;
  import pnd_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [3:0] pstrb_in = 4'h0;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [CHAN_N-1:0] cm_a;
  logic [CHAN_N-1:0] cm_b;
  logic [DATA_W-1:0] pin_pattern_high_out;
  logic [7:0] rd_v;
  logic rd_e;
  logic [7:0] pin_exp = 8'h00;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;

  always #10 clk_in = ~clk_in;

  pnd_next_data u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .cm_a_in(cm_a), .cm_b_in(cm_b),
    .pin_pattern_high_out(pin_pattern_high_out));
  pnd_timer_model u_tmr (.clk_in(clk_in), .nrst_in(nrst_in), .cm_a_out(cm_a), .cm_b_out(cm_b));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Request is held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h000000, d};
    pstrb_in <= s;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("[FAIL] %0t no bus answer", $time);
    end
    rd_v = prdata_out[7:0];
    rd_e = pslverr_out;
    total_checks++;
    if (prdata_out[31:8] !== 24'h000000) begin
      fail_count++;
      $display("[FAIL] %0t read data upper bits not zero", $time);
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic err);
    apb(1'b1, a, d, 4'h1);
    check({7'h00, rd_e}, {7'h00, err}, "write error flag");
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp, input logic err);
    apb(1'b0, a, 8'h00, 4'h0);
    check({7'h00, rd_e}, {7'h00, err}, "read error flag");
    check(rd_v, exp, "read data");
  endtask : rd

  // Strobe, then give the pin register time to follow
  task automatic fire(input int ch, input logic is_b, input int gap);
    u_tmr.match(ch, is_b, gap);
    repeat (2) @(posedge clk_in);
    check(pin_pattern_high_out, pin_exp, "pin pattern");
  endtask : fire

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(OFS_SEL, SEL_RST, 1'b0);
    rd(OFS_HI_JOINT, NEXT_RST, 1'b0);
    rd(OFS_LO_JOINT, NEXT_RST, 1'b0);
    rd(OFS_MODE, MODE_RST, 1'b0);
    rd(OFS_BIT_EN, EN_RST, 1'b0);
    rd(OFS_PIN, PIN_RST, 1'b0);
    check(pin_pattern_high_out, PIN_RST, "pin after reset");
  endtask : t_reset

  task automatic t_joint();
    wr(OFS_HI_JOINT, 8'hA5, 1'b0);
    rd(OFS_HI_JOINT, 8'hA5, 1'b0);
    rd(OFS_HI_UPPER, 8'h00, 1'b1);
    wr(OFS_LO_JOINT, 8'h3C, 1'b0);
    rd(OFS_LO_JOINT, 8'h3C, 1'b0);
    rd(12'h020, 8'h00, 1'b1);
    apb(1'b1, OFS_LO_JOINT, 8'hFF, 4'h0);
    rd(OFS_LO_JOINT, 8'h3C, 1'b0);
  endtask : t_joint

  task automatic t_select();
    logic [7:0] sel;
    logic [7:0] pat;
    wr(OFS_BIT_EN, 8'hFF, 1'b0);
    for (int k = 0; k < 4; k++) begin
      sel = {2'(k), 2'(k), 4'(k) * 4'h5};
      pat = 8'h96 + 8'(k) * 8'h35;
      wr(OFS_SEL, sel, 1'b0);
      rd(OFS_SEL, sel, 1'b0);
      wr(OFS_HI_JOINT, pat, 1'b0);
      fire((k + 1) % 4, 1'b0, 3);
      fire(k, 1'b1, 3);
      pin_exp = pat;
      fire(k, 1'b0, 3 + 5 * k);
    end
  endtask : t_select

  task automatic t_enable();
    wr(OFS_BIT_EN, 8'h3C, 1'b0);
    wr(OFS_HI_JOINT, 8'hCA, 1'b0);
    pin_exp = (pin_exp & ~8'h3C) | (8'hCA & 8'h3C);
    fire(3, 1'b0, 3);
    rd(OFS_BIT_EN, 8'h3C, 1'b0);
    // Software pin write reaches only the bits not under pulse control
    wr(OFS_PIN, 8'hFF, 1'b0);
    pin_exp = 8'hCB;
    rd(OFS_PIN, pin_exp, 1'b0);
    check(pin_pattern_high_out, pin_exp, "software pin write");
    wr(OFS_BIT_EN, 8'hFF, 1'b0);
  endtask : t_enable

  task automatic t_split();
    wr(OFS_SEL, 8'h1F, 1'b0);
    rd(OFS_HI_JOINT, 8'h00, 1'b1);
    wr(OFS_HI_UPPER, 8'h53, 1'b0);
    rd(OFS_HI_UPPER, 8'h5F, 1'b0);
    wr(OFS_HI_LOWER, 8'hC6, 1'b0);
    rd(OFS_HI_LOWER, 8'hF6, 1'b0);
    rd(OFS_HI_UPPER, 8'h5F, 1'b0);
    pin_exp = {4'h5, pin_exp[3:0]};
    fire(0, 1'b0, 3);
    pin_exp = 8'h56;
    fire(1, 1'b0, 20);
  endtask : t_split

  task automatic t_nonoverlap();
    wr(OFS_SEL, 8'hAA, 1'b0);
    wr(OFS_MODE, 8'hFC, 1'b0);
    rd(OFS_MODE, 8'hFC, 1'b0);
    wr(OFS_HI_JOINT, 8'hF0, 1'b0);
    pin_exp = 8'hF0;
    fire(2, 1'b0, 3);
    wr(OFS_HI_JOINT, 8'h0F, 1'b0);
    pin_exp = 8'h00;
    fire(2, 1'b1, 3);
    pin_exp = 8'h0F;
    fire(2, 1'b0, 3);
  endtask : t_nonoverlap

  // ****************************************
  // Main sequence and hang guard
  // ****************************************
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      $display("[FAIL] %0t run did not finish", $time);
      test_done();
    end
  end

  initial begin
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset();
    t_joint();
    t_select();
    t_enable();
    t_split();
    t_nonoverlap();
    test_done();
  end
endmodule : test_pulse_next_data_trigger_select
